// ===== rtl/ppsh_pkg.sv
`default_nettype none
package ppsh_pkg;
  // ---------------------------------------------------------------
  // Register map (byte indices on the plain port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PORT_A     = 4'h0;
  localparam logic [3:0] ADDR_PORT_B     = 4'h1;
  localparam logic [3:0] ADDR_PORT_C     = 4'h2;
  localparam logic [3:0] ADDR_PORT_CL    = 4'h3;
  localparam logic [3:0] ADDR_PORT_C_DIR = 4'h4;
  localparam logic [3:0] ADDR_PORT_D     = 4'h5;
  localparam logic [3:0] ADDR_PORT_D_DIR = 4'h6;
  localparam logic [3:0] ADDR_PORT_E     = 4'h7;
  localparam logic [3:0] ADDR_HS_CTRL    = 4'h8;
  localparam logic [3:0] ADDR_PA7_DIR    = 4'h9;
  // ---------------------------------------------------------------
  // Handshake control bits
  // ---------------------------------------------------------------
  localparam int BIT_FLAG   = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_FULL   = 4;
  localparam int BIT_OUT_HS = 3;
  localparam int BIT_PULSE  = 2;
  localparam int BIT_EDGE   = 1;
  localparam int BIT_POL    = 0;
  localparam logic [7:0] HS_CTRL_RST = 8'h00;
  localparam logic [7:0] HS_CTRL_WMASK = 8'h5f;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] PA_OUT_MASK = 8'h78;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int STROBE_CYCLES = 2;
  localparam logic [1:0] STROBE_CNT = 2'(STROBE_CYCLES);
endpackage : ppsh_pkg
`default_nettype wire

// ===== rtl/ppsh_sync.sv
`default_nettype none
module ppsh_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Data
  input  wire logic d_in,
  output logic      q_out
);
  import ppsh_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
  } ppsh_sync_t;
  ppsh_sync_t st_ff;
  ppsh_sync_t nxt_st;

  // Two stage synchroniser
  always_comb begin
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q_out = st_ff.s2;
endmodule // ppsh_sync
`default_nettype wire

// ===== rtl/ppsh_top.sv
`default_nettype none
module ppsh_top (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Mode
  input  wire logic       single_chip,
  // Port A
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe_n,
  // Port B
  output logic      [7:0] port_b_out,
  // Port C
  input  wire logic [7:0] port_c_in,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe_n,
  // Port D
  input  wire logic [7:0] port_d_in,
  output logic      [7:0] port_d_out,
  output logic      [7:0] port_d_oe_n,
  // Port E
  input  wire logic [7:0] port_e_in,
  // Strobes
  input  wire logic       strobe_in_pin,
  output logic            strobe_out_pin,
  // Interrupt request
  output logic            strobe_irq
);
  import ppsh_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic       strobe_in_pin_s;
  logic [7:0] pa_s;
  logic [7:0] pc_s;
  logic [7:0] pd_s;
  logic [7:0] pe_s;
  logic [32:0] raw_in;
  logic [32:0] sync_out;
  assign raw_in = {strobe_in_pin, port_a_in, port_c_in, port_d_in, port_e_in};
  // Strobe goes through the same two flops as the ports
  for (genvar i = 0; i < 33; i++) begin : g_sync
    ppsh_sync u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d_in  (raw_in[i]),
      .q_out (sync_out[i])
    );
  end
  assign {strobe_in_pin_s, pa_s, pc_s, pd_s, pe_s} = sync_out;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pa_out;
    logic       pa7_dir;
    logic [7:0] pb_out;
    logic [7:0] pc_out;
    logic [7:0] pc_dir;
    logic [7:0] pd_out;
    logic [7:0] pd_dir;
    logic [7:0] capture;
    logic       flag;
    logic       irq_en;
    logic       full;
    logic       out_hs;
    logic       pulse;
    logic       edge_sel;
    logic       pol;
    logic       armed;
    logic       strobe_in_pin_d;
    logic [1:0] pb_cnt;
    logic [1:0] rdy_cnt;
    logic       rdy;
    logic [7:0] rdata;
  } ppsh_state_t;
  ppsh_state_t st_ff;
  ppsh_state_t nxt_st;

  logic edge_hit;
  logic active_lvl;
  logic hs_mode;
  logic out_hs_mode;
  logic [7:0] hs_rd;

  // Edge detection compares the synchronised level with last cycle
  assign hs_mode     = single_chip;
  assign edge_hit    = hs_mode & (st_ff.edge_sel ? (strobe_in_pin_s & ~st_ff.strobe_in_pin_d)
                                                 : (~strobe_in_pin_s & st_ff.strobe_in_pin_d));
  assign active_lvl  = st_ff.edge_sel ? ~strobe_in_pin_s : strobe_in_pin_s;
  assign out_hs_mode = st_ff.full & st_ff.out_hs;
  assign hs_rd = {st_ff.flag, st_ff.irq_en, 1'b0, st_ff.full, st_ff.out_hs,
                  st_ff.pulse, st_ff.edge_sel, st_ff.pol};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe_in_pin_d = strobe_in_pin_s;
    if (st_ff.pb_cnt != 2'h0) begin
      nxt_st.pb_cnt = st_ff.pb_cnt - 2'h1;
    end
    if (st_ff.pulse && st_ff.rdy_cnt != 2'h0) begin
      nxt_st.rdy_cnt = st_ff.rdy_cnt - 2'h1;
    end
    // Read data, valid the cycle after the strobe only
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        // Input pins sensed, output bits read driver input; port C in output handshake reads its whole latch
        ADDR_PORT_A: nxt_st.rdata = (st_ff.pa_out & PA_OUT_MASK)
                                  | (pa_s & ~PA_OUT_MASK & {~st_ff.pa7_dir, 7'h7f})
                                  | ({st_ff.pa7_dir, 7'h00} & st_ff.pa_out);
        ADDR_PORT_B: nxt_st.rdata = st_ff.pb_out;
        ADDR_PORT_C: nxt_st.rdata = out_hs_mode ? st_ff.pc_out
                                  : (st_ff.pc_out & st_ff.pc_dir) | (pc_s & ~st_ff.pc_dir);
        ADDR_PORT_CL:    nxt_st.rdata = st_ff.capture;
        ADDR_PORT_C_DIR: nxt_st.rdata = st_ff.pc_dir;
        ADDR_PORT_D: nxt_st.rdata = (st_ff.pd_out & st_ff.pd_dir) | (pd_s & ~st_ff.pd_dir);
        ADDR_PORT_D_DIR: nxt_st.rdata = st_ff.pd_dir;
        ADDR_PORT_E:     nxt_st.rdata = pe_s;
        ADDR_HS_CTRL:    nxt_st.rdata = hs_rd;
        ADDR_PA7_DIR:    nxt_st.rdata = {7'h00, st_ff.pa7_dir};
        default:         nxt_st.rdata = 8'h00;
      endcase
      // Arm the clear sequence when the flag was seen set
      if (reg_addr == ADDR_HS_CTRL) begin
        nxt_st.armed = st_ff.flag;
      end
      if (reg_addr == ADDR_PORT_CL) begin
        if (st_ff.armed && !out_hs_mode) begin
          nxt_st.flag  = 1'b0;
          nxt_st.armed = 1'b0;
        end
        // Reading the latch readies the next input transfer
        if (st_ff.full && !st_ff.out_hs) begin
          nxt_st.rdy     = 1'b1;
          nxt_st.rdy_cnt = STROBE_CNT;
        end
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PORT_A: nxt_st.pa_out = reg_wdata & {1'b1, PA_OUT_MASK[6:0]};
        ADDR_PORT_B: begin
          nxt_st.pb_out = reg_wdata;
          if (!st_ff.full && hs_mode) begin
            nxt_st.pb_cnt = STROBE_CNT;
          end
        end
        ADDR_PORT_C: nxt_st.pc_out = reg_wdata;
        ADDR_PORT_CL: begin
          nxt_st.pc_out = reg_wdata;
          if (out_hs_mode) begin
            if (st_ff.armed) begin
              nxt_st.flag  = 1'b0;
              nxt_st.armed = 1'b0;
            end
            // New data: announce ready
            nxt_st.rdy     = 1'b1;
            nxt_st.rdy_cnt = STROBE_CNT;
          end
        end
        ADDR_PORT_C_DIR: nxt_st.pc_dir = reg_wdata;
        ADDR_PORT_D:     nxt_st.pd_out = reg_wdata;
        ADDR_PORT_D_DIR: nxt_st.pd_dir = reg_wdata;
        ADDR_HS_CTRL: begin
          nxt_st.irq_en   = reg_wdata[BIT_IRQ_EN];
          nxt_st.full     = reg_wdata[BIT_FULL];
          nxt_st.out_hs   = reg_wdata[BIT_OUT_HS];
          nxt_st.pulse    = reg_wdata[BIT_PULSE];
          nxt_st.edge_sel = reg_wdata[BIT_EDGE];
          nxt_st.pol      = reg_wdata[BIT_POL];
        end
        ADDR_PA7_DIR: nxt_st.pa7_dir = reg_wdata[0];
        default: ;
      endcase
    end
    // Strobe edge: capture and flag; set wins over a clear
    if (edge_hit) begin
      nxt_st.capture = pc_s;
      nxt_st.flag    = 1'b1;
      if (st_ff.full) begin
        nxt_st.rdy     = 1'b0;
        nxt_st.rdy_cnt = 2'h0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic rdy_act;
  logic sb_act;
  // Pulsed ready stands two cycles, interlocked until the edge
  assign rdy_act = st_ff.rdy & (~st_ff.pulse | (st_ff.rdy_cnt != 2'h0));
  assign sb_act  = st_ff.full ? rdy_act : (st_ff.pb_cnt != 2'h0);
  assign strobe_out_pin = hs_mode ? (sb_act ~^ st_ff.pol) : 1'b0;
  assign strobe_irq  = st_ff.flag & st_ff.irq_en;
  assign reg_rdata   = st_ff.rdata;
  assign port_a_out  = st_ff.pa_out & {1'b1, PA_OUT_MASK[6:0]};
  assign port_a_oe_n = ~{st_ff.pa7_dir, PA_OUT_MASK[6:0]};
  assign port_b_out  = st_ff.pb_out;
  assign port_c_out  = st_ff.pc_out;
  // Three-state variant forces all lines while the strobe is active
  assign port_c_oe_n = ~((out_hs_mode && hs_mode && active_lvl) ? 8'hff : st_ff.pc_dir);
  assign port_d_out  = st_ff.pd_out;
  assign port_d_oe_n = ~st_ff.pd_dir;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_ctrl_rd_set;
    reg_rd && reg_addr == ADDR_HS_CTRL && st_ff.flag;
  endsequence
  sequence s_latch_rd;
    reg_rd && reg_addr == ADDR_PORT_CL && !reg_wr;
  endsequence

  a_edge_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    edge_hit |=> st_ff.flag && st_ff.capture == $past(pc_s)) else $error("edge did not capture");
  // One idle bus cycle between the two steps, as the bus master spaces them
  a_flag_clear_rd: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ctrl_rd_set ##1 (!reg_rd && !reg_wr) ##1 (s_latch_rd and (!out_hs_mode && !edge_hit))
    |=> !st_ff.flag) else $error("flag not cleared by read pair");
  a_flag_clear_wr: assert property (@(posedge mclk) disable iff (!rst_n)
    s_ctrl_rd_set ##1 (!reg_rd && !reg_wr)
    ##1 (reg_wr && reg_addr == ADDR_PORT_CL && out_hs_mode && !edge_hit && !reg_rd)
    |=> !st_ff.flag) else $error("flag not cleared by write");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    strobe_irq == (st_ff.flag && st_ff.irq_en)) else $error("irq mismatch");
  a_pb_strobe: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == ADDR_PORT_B && !st_ff.full && hs_mode)
    |=> (strobe_out_pin == st_ff.pol)[*2]) else $error("port B strobe not two cycles");
  a_rdy_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    (edge_hit && st_ff.full && !(reg_wr || reg_rd)) |=> !rdy_act) else $error("ready not dropped");
  a_rdy_raise: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_latch_rd and (st_ff.full && !st_ff.out_hs && !edge_hit && hs_mode)) |=> rdy_act)
    else $error("ready not raised");
  a_force_out: assert property (@(posedge mclk) disable iff (!rst_n)
    (out_hs_mode && hs_mode && active_lvl) |-> port_c_oe_n == 8'h00) else $error("port C not forced");
  a_pe_no_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_wr && reg_addr == ADDR_PORT_E) |=> $stable(st_ff.pd_out) && $stable(st_ff.pc_out))
    else $error("port E write changed state");
endmodule // ppsh_top
`default_nettype wire

// ===== dv/ppsh_far.sv
`default_nettype none
module ppsh_far (
  // Clock
  input  wire logic       mclk,
  // Ready line from the block
  input  wire logic       ready,
  // Strobe and data towards the block
  output var  logic       strobe,
  output var  logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  // -----------------------------------------------------------------
  // Far party behaviour
  // -----------------------------------------------------------------
  // Idle levels before the first transfer
  initial begin
    strobe = 1'b1;
    data   = 8'h5a;
  end
  // Move the strobe line to a new static level
  task automatic level(input logic lvl);
    @(posedge mclk);
    strobe <= lvl;
  endtask
  // Ready first if wait_rdy, then data, then the edge; data inverted after its hold
  task automatic send(input logic [7:0] d, input logic rise, input logic wait_rdy,
                      input logic rdy_lvl, output logic ok);
    int i;
    ok = 1'b1;
    if (wait_rdy) begin
      ok = 1'b0;
      for (i = 0; i < 50 && !ok; i++) begin
        @(posedge mclk);
        ok = (ready === rdy_lvl);
      end
    end
    @(posedge mclk);
    data   <= d;
    strobe <= ~rise;
    repeat (4) @(posedge mclk);
    strobe <= rise;
    // Inverted, not held, so a stale capture cannot pass
    repeat (8) @(posedge mclk);
    data <= ~d;
  endtask
endmodule // ppsh_far
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppsh_pkg::*;
  // -----------------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------------
  logic       mclk, reset_n, reg_wr, reg_rd, single_chip, stb_out, irq, far_stb, ok;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, pa_in, pa_out, pa_oe_n, pb_out, pc_in, pc_out, pc_oe_n;
  logic [7:0] pd_in, pd_out, pd_oe_n, pe_in, far_c;
  int         fail_count, n_compared;
  // Pin levels: our driver where enabled, else the outside party
  assign pa_in = (pa_oe_n & 8'h85) | (~pa_oe_n & pa_out);
  assign pc_in = (pc_oe_n & far_c) | (~pc_oe_n & pc_out);
  assign pd_in = (pd_oe_n & 8'hc3) | (~pd_oe_n & pd_out);
  ppsh_top uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .single_chip(single_chip), .port_a_in(pa_in), .port_a_out(pa_out),
    .port_a_oe_n(pa_oe_n), .port_b_out(pb_out), .port_c_in(pc_in), .port_c_out(pc_out), .port_c_oe_n(pc_oe_n),
    .port_d_in(pd_in), .port_d_out(pd_out), .port_d_oe_n(pd_oe_n), .port_e_in(pe_in), .strobe_in_pin(far_stb),
    .strobe_out_pin(stb_out), .strobe_irq(irq));
  ppsh_far u_far (.mclk(mclk), .ready(stb_out), .strobe(far_stb), .data(far_c));
  // -----------------------------------------------------------------
  // Shared helpers
  // -----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Width of the next active pulse, sampled at falling edges
  task automatic plen(input logic lvl, input int exp);
    int i;
    int k;
    k = 0;
    @(negedge mclk);
    for (i = 0; i < 20 && stb_out !== lvl; i++) @(negedge mclk);
    while (stb_out === lvl && k < 20) begin
      k++;
      @(negedge mclk);
    end
    chk(8'(k), 8'(exp));
  endtask
  task automatic complete_run;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset;
    chk(pc_oe_n, 8'hff);
    chk(pd_oe_n, 8'hff);
    chk(pa_oe_n, 8'h87);
    chk(8'(stb_out), 8'h01);
    rdc(ADDR_PORT_C_DIR, 8'h00);
    rdc(ADDR_PORT_D_DIR, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_dirs;
    wr(ADDR_PORT_C, 8'ha5);
    rdc(ADDR_PORT_C, 8'h5a);
    chk(pc_oe_n, 8'hff);
    wr(ADDR_PORT_C_DIR, 8'hf0);
    cyc(1);
    chk(pc_out & 8'hf0, 8'ha0);
    chk(pc_oe_n, 8'h0f);
    rdc(ADDR_PORT_C, 8'haa);
    wr(ADDR_PORT_CL, 8'h3c);
    cyc(1);
    chk(pc_out, 8'h3c);
    wr(ADDR_PORT_C_DIR, 8'h00);
    wr(ADDR_PORT_D_DIR, 8'hff);
    wr(ADDR_PORT_D, 8'h96);
    cyc(1);
    chk(pd_oe_n, 8'h00);
    rdc(ADDR_PORT_D, 8'h96);
    $display("t_dirs done");
  endtask
  task automatic t_fixed;
    wr(ADDR_PORT_A, 8'hff);
    cyc(1);
    chk(pa_out & 8'h7f, 8'h78);
    rdc(ADDR_PORT_A, 8'hfd);
    wr(ADDR_PA7_DIR, 8'h01);
    cyc(1);
    chk(pa_oe_n, 8'h07);
    wr(ADDR_PORT_A, 8'h00);
    rdc(ADDR_PORT_A, 8'h05);
    wr(ADDR_PORT_B, 8'h69);
    rdc(ADDR_PORT_B, 8'h69);
    chk(pb_out, 8'h69);
    wr(ADDR_PORT_E, 8'h00);
    rdc(ADDR_PORT_E, 8'h3e);
    rdc(4'hf, 8'h00);
    $display("t_fixed done");
  endtask
  task automatic t_simple;
    wr(ADDR_HS_CTRL, 8'h40);
    wr(ADDR_PORT_B, 8'h11);
    plen(1'b0, 2);
    wr(ADDR_HS_CTRL, 8'h41);
    wr(ADDR_PORT_B, 8'h22);
    plen(1'b1, 2);
    wr(ADDR_HS_CTRL, 8'h40);
    u_far.send(8'h3c, 1'b0, 1'b0, 1'b0, ok);
    chk(8'(irq), 8'h01);
    u_far.send(8'h99, 1'b0, 1'b0, 1'b0, ok);
    rdc(ADDR_HS_CTRL, 8'hc0);
    rdc(ADDR_PORT_CL, 8'h99);
    rdc(ADDR_HS_CTRL, 8'h40);
    chk(8'(irq), 8'h00);
    $display("t_simple done");
  endtask
  task automatic t_in_hs;
    wr(ADDR_HS_CTRL, 8'h13);
    cyc(2);
    chk(8'(stb_out), 8'h00);
    rdc(ADDR_PORT_CL, 8'h99);
    cyc(2);
    chk(8'(stb_out), 8'h01);
    u_far.send(8'h4b, 1'b1, 1'b1, 1'b1, ok);
    chk(8'(ok), 8'h01);
    chk(8'(stb_out), 8'h00);
    rdc(ADDR_HS_CTRL, 8'h93);
    rdc(ADDR_PORT_CL, 8'h4b);
    rdc(ADDR_PORT_C, 8'hb4);
    wr(ADDR_HS_CTRL, 8'h17);
    rdc(ADDR_PORT_CL, 8'h4b);
    plen(1'b1, 2);
    $display("t_in_hs done");
  endtask
  task automatic t_out_hs;
    wr(ADDR_HS_CTRL, 8'h18);
    wr(ADDR_PORT_CL, 8'he7);
    cyc(3);
    chk(pc_oe_n, 8'h00);
    chk(8'(stb_out), 8'h00);
    u_far.level(1'b0);
    cyc(5);
    chk(pc_oe_n, 8'hff);
    chk(8'(stb_out), 8'h01);
    rdc(ADDR_PORT_C, 8'he7);
    rdc(ADDR_HS_CTRL, 8'h98);
    wr(ADDR_PORT_CL, 8'h81);
    rdc(ADDR_HS_CTRL, 8'h18);
    $display("t_out_hs done");
  endtask
  task automatic t_bus;
    @(posedge mclk);
    single_chip <= 1'b0;
    wr(ADDR_HS_CTRL, 8'h40);
    u_far.level(1'b1);
    cyc(4);
    u_far.level(1'b0);
    cyc(5);
    rdc(ADDR_HS_CTRL, 8'h40);
    wr(ADDR_PORT_B, 8'h5a);
    plen(1'b1, 0);
    $display("t_bus done");
  endtask
  // -----------------------------------------------------------------
  // Clock and main sequence
  // -----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    single_chip = 1'b1;
    pe_in       = 8'h3e;
    fail_count  = 0;
    n_compared  = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    // Requests wait out the two-flop reset release
    repeat (3) @(posedge mclk);
    t_reset();
    t_dirs();
    t_fixed();
    t_simple();
    t_in_hs();
    t_out_hs();
    t_bus();
    complete_run();
  end
endmodule // tb
`default_nettype wire
